//--- dv/rxfa_line_src.sv
// Line-side source model that sends the framing bytes of good or corrupted frames.
`timescale 1ns/10ps
`default_nettype none
module rxfa_line_src
	import rxfa_pkg::*;
(
	input wire logic i_clk,
	output rxfa_pkg::rxfa_line_t o_line
);
	logic busy = 1'b0;
	initial o_line = '0;
	// Between frames the byte lines keep changing, so no stale byte can pass for a framing byte.
	always @(posedge i_clk) begin
		if (!busy) begin
			o_line.byte_data <= o_line.byte_data + 8'h01;
			o_line.valid <= 1'b0;
			o_line.frame_start <= 1'b0;
		end
	end
	task automatic send(input logic good, input int pos = 17);
		logic [7:0] b;
		busy = 1'b1;
		for (int i = 0; i < 18; i++) begin
			b = (i < 9) ? A1_PATTERN : A2_PATTERN;
			if (!good && i == pos) b = ~b;
			@(posedge i_clk);
			o_line <= '{b, 1'b1, i == 0};
		end
		@(posedge i_clk);
		o_line.valid <= 1'b0;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the receive framer registers, alignment machine and path AIS.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rxfa_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, irq_n, ais, poh, lcd, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic e;
	rxfa_line_t line;
	rxfa_defect_t dfc;
	rxfa_event_t ev;
	int err_total = 0;
	int checks = 0;
	rxfa_top uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_line(line), .i_defect(dfc), .i_event(ev),
		.o_irq_n(irq_n), .o_path_ais(ais), .o_poh_ais_defect(poh), .o_cell_lcd_defect(lcd));
	rxfa_line_src src (.i_clk(clk), .o_line(line));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic report_and_stop();
		if (err_total == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		#50us;
		err_total++;
		report_and_stop();
	end
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		dfc = '0;
		ev = '0;
		waitc(4);
		rst_n <= 1'b1;
		rd(16'h441C, 32'h06);
		rd(16'h458C, 32'h03);
		rd(16'h442C, 32'h00);
		rd(16'h4000, 32'h00);
		chk(e, 1'b1);
		apb(1'b1, 16'h441C, 32'hFF);
		rd(16'h441C, 32'h06);
		// Two clean frames take the machine out of the severely errored state.
		src.send(1'b1);
		src.send(1'b1);
		waitc(6);
		rd(16'h441C, 32'h04);
		chk(irq_n, 1'b0);
		rd(16'h442C, 32'h02);
		rd(16'h442C, 32'h00);
		waitc(3);
		chk(irq_n, 1'b1);
		apb(1'b1, 16'h458C, 32'h05);
		waitc(3);
		chk({ais, poh, lcd}, 3'b111);
		apb(1'b1, 16'h458C, 32'h04);
		waitc(3);
		chk({ais, poh, lcd}, 3'b000);
		rd(16'h458C, 32'h04);
		dfc.los <= 1'b1;
		waitc(2);
		rd(16'h441C, 32'h05);
		dfc.los <= 1'b0;
		waitc(2);
		rd(16'h441C, 32'h04);
		rd(16'h442C, 32'h01);
		@(posedge clk);
		ev <= '{1'b0, 1'b0, 1'b1};
		@(posedge clk);
		ev <= '0;
		rd(16'h442C, 32'h08);
		// Four framing failures in a row drop back to both defects declared.
		repeat (4) src.send(1'b0);
		waitc(6);
		rd(16'h441C, 32'h06);
		rd(16'h442C, 32'h02);
		// A one-frame in-sync threshold lets a third clean frame declare frame.
		apb(1'b1, 16'h44AC, 32'h01);
		rd(16'h44AC, 32'h01);
		repeat (3) src.send(1'b1);
		waitc(6);
		rd(16'h441C, 32'h00);
		rd(16'h442C, 32'h06);
		// Masked interrupts keep the pin quiet while bad A1 bytes raise SEF alone.
		apb(1'b1, 16'h443C, 32'h00);
		repeat (4) src.send(1'b0, 0);
		waitc(6);
		rd(16'h441C, 32'h02);
		chk(irq_n, 1'b1);
		rd(16'h442C, 32'h02);
		apb(1'b1, 16'h443C, 32'hFF);
		rd(16'h443C, 32'hFF);
		repeat (2) src.send(1'b1);
		waitc(6);
		rd(16'h441C, 32'h00);
		chk(irq_n, 1'b0);
		rd(16'h442C, 32'h02);
		report_and_stop();
	end
endmodule
`default_nettype wire

//--- hdl/rxfa_top.sv
// Receive framing alignment, defect reporting and automatic downstream path AIS.
// What this block does
// - Auto_alarm_master_enable register: bit 0 master enable, bits 1-7 per-defect AIS enables.
// - Sending path AIS downstream makes the path overhead side declare AIS.
// - Sending path AIS downstream makes the cell processor declare loss of delineation.
// - Alignment machine is always in exactly one of four modes.
// - Starts in SEF=1/LOF=1 with status bits 2 and 1 set.
// - Two consecutive error-free frames clear SEF and enter SEF=0/LOF=1.
// - Entering SEF=0/LOF=1 clears status bit 1, keeps LOF set.
// - Any SEF change sets interrupt bit 1 and, while interrupt enable bit 1 is set, pulls the interrupt low.
// - Read-only defect status register, bits RDI-L down to LOS.
// - Interrupt status register of change and error bits, cleared by reading.
// - LOS clearing clears status bit 0, sets interrupt bit 0.
`timescale 1ns/10ps
`default_nettype none
module rxfa_top (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [rxfa_pkg::APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire rxfa_pkg::rxfa_line_t i_line,
	input wire rxfa_pkg::rxfa_defect_t i_defect,
	input wire rxfa_pkg::rxfa_event_t i_event,
	output logic o_irq_n,
	output logic o_path_ais,
	output logic o_poh_ais_defect,
	output logic o_cell_lcd_defect
);
	import rxfa_pkg::*;

	rxfa_state_t state_r, state_nxt;
	logic [4:0] byte_cnt_r;
	logic chk_active_r;
	logic chk_err_r;
	logic frame_done_r;
	logic frame_bad_r;
	logic [4:0] good_cnt_r, good_nxt;
	logic [4:0] bad_cnt_r, bad_nxt;
	logic [7:0] auto_alarm_master_enable_r;
	logic [7:0] irq_en_r;
	logic [7:0] irq_r, irq_nxt;
	logic [3:0] in_sync_r;
	logic sef_d_r, lof_d_r, los_d_r, sd_d_r, sf_d_r;
	logic sef_w, lof_w;
	logic [7:0] status_w;
	logic [7:0] events_w;
	logic [13:0] idx_w;
	logic apb_fire;
	logic ais_cond;
	logic [4:0] cur_idx;
	logic [7:0] exp_byte;
	logic cur_bad;
	logic [4:0] sync_need;

	assign idx_w = i_paddr[15:2];
	assign apb_fire = i_psel & i_penable & o_pready;
	assign sef_w = (state_r == FA_SEF1_LOF0) | (state_r == FA_SEF1_LOF1);
	assign lof_w = (state_r == FA_SEF1_LOF1) | (state_r == FA_SEF0_LOF1);
	// Status is decoded live from the machine so it can never disagree with it.
	assign status_w = {i_defect.rdi_l, i_defect.s1_unstable, i_defect.k1k2_unstable,
		i_defect.sf, i_defect.sd, lof_w, sef_w, i_defect.los};

	// Framing byte check: 9 A1 then 9 A2 bytes follow each frame start.
	assign cur_idx = i_line.frame_start ? 5'h00 : byte_cnt_r;
	assign exp_byte = (cur_idx < A1_BYTES) ? A1_PATTERN : A2_PATTERN;
	assign cur_bad = (i_line.byte_data != exp_byte) | (~i_line.frame_start & chk_err_r);

	// A zero threshold still asks for one clean frame, or a bad frame would end LOF.
	assign sync_need = (in_sync_r == 4'h0) ? 5'h01 : {1'b0, in_sync_r};

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			byte_cnt_r <= 5'h00;
			chk_active_r <= 1'b0;
			chk_err_r <= 1'b0;
			frame_done_r <= 1'b0;
			frame_bad_r <= 1'b0;
		end else begin
			frame_done_r <= 1'b0;
			if (i_line.valid && (i_line.frame_start || chk_active_r)) begin
				if (cur_idx == LAST_FRAMING_BYTE) begin
					frame_done_r <= 1'b1;
					frame_bad_r <= cur_bad;
					chk_active_r <= 1'b0;
					byte_cnt_r <= 5'h00;
				end else begin
					byte_cnt_r <= cur_idx + 5'h01;
					chk_err_r <= cur_bad;
					chk_active_r <= 1'b1;
				end
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		good_nxt = good_cnt_r;
		bad_nxt = bad_cnt_r;
		if (frame_done_r) begin
			if (frame_bad_r) begin
				bad_nxt = (bad_cnt_r == CNT_MAX) ? CNT_MAX : bad_cnt_r + 5'h01;
				good_nxt = 5'h00;
			end else begin
				good_nxt = (good_cnt_r == CNT_MAX) ? CNT_MAX : good_cnt_r + 5'h01;
				bad_nxt = 5'h00;
			end
			unique case (state_r)
				FA_IN_FRAME: begin
					if (bad_nxt >= SEF_DECLARE_FRAMES)
						state_nxt = FA_SEF1_LOF0;
				end
				FA_SEF1_LOF0: begin
					if (good_nxt >= SEF_CLEAR_FRAMES)
						state_nxt = FA_IN_FRAME;
					else if (bad_nxt >= LOF_DECLARE_FRAMES)
						state_nxt = FA_SEF1_LOF1;
				end
				FA_SEF1_LOF1: begin
					if (good_nxt >= SEF_CLEAR_FRAMES)
						state_nxt = FA_SEF0_LOF1;
				end
				FA_SEF0_LOF1: begin
					if (good_nxt >= sync_need)
						state_nxt = FA_IN_FRAME;
					else if (bad_nxt >= SEF_DECLARE_FRAMES)
						state_nxt = FA_SEF1_LOF1;
				end
				default: state_nxt = FA_SEF1_LOF1;
			endcase
			if (state_nxt != state_r) begin
				good_nxt = 5'h00;
				bad_nxt = 5'h00;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_r <= FA_SEF1_LOF1;
			good_cnt_r <= 5'h00;
			bad_cnt_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			good_cnt_r <= good_nxt;
			bad_cnt_r <= bad_nxt;
		end
	end

	// Edge detectors start at the reset picture so leaving reset raises no false change.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			sef_d_r <= 1'b1;
			lof_d_r <= 1'b1;
			los_d_r <= 1'b0;
			sd_d_r <= 1'b0;
			sf_d_r <= 1'b0;
		end else begin
			sef_d_r <= sef_w;
			lof_d_r <= lof_w;
			los_d_r <= i_defect.los;
			sd_d_r <= i_defect.sd;
			sf_d_r <= i_defect.sf;
		end
	end

	assign events_w = {sf_d_r ^ i_defect.sf, sd_d_r ^ i_defect.sd, i_event.rei_l,
		i_event.b2_err, i_event.b1_err, lof_d_r ^ lof_w,
		sef_d_r ^ sef_w, los_d_r ^ i_defect.los};

	// Only the bits handed out in the read data are cleared, so an event that lands
	// between the capture and the end of the read survives, and a set beats the clear.
	always_comb begin
		irq_nxt = irq_r;
		if (apb_fire && !i_pwrite && idx_w == IDX_IRQ_STATUS)
			irq_nxt = irq_r & ~o_prdata[7:0];
		irq_nxt = irq_nxt | events_w;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			irq_r <= RST_IRQ_STATUS;
			o_irq_n <= 1'b1;
		end else begin
			irq_r <= irq_nxt;
			o_irq_n <= ~|(irq_r & irq_en_r);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			auto_alarm_master_enable_r <= RST_AUTO_ALARM_MASTER_ENABLE;
			irq_en_r <= RST_IRQ_ENABLE;
			in_sync_r <= RST_IN_SYNC;
		end else if (apb_fire && i_pwrite) begin
			if (idx_w == IDX_AUTO_ALARM_MASTER_ENABLE)
				auto_alarm_master_enable_r <= i_pwdata[7:0];
			if (idx_w == IDX_IRQ_ENABLE)
				irq_en_r <= i_pwdata[7:0];
			if (idx_w == IDX_IN_SYNC)
				in_sync_r <= i_pwdata[3:0];
		end
	end

	// One wait state: read data is captured when pready rises.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & i_penable & ~o_pready;
			if (i_psel && i_penable && !o_pready) begin
				o_pslverr <= 1'b0;
				unique case (idx_w)
					IDX_STATUS: o_prdata <= {24'h000000, status_w};
					IDX_IRQ_STATUS: o_prdata <= {24'h000000, irq_r};
					IDX_IRQ_ENABLE: o_prdata <= {24'h000000, irq_en_r};
					IDX_IN_SYNC: o_prdata <= {28'h0000000, in_sync_r};
					IDX_AUTO_ALARM_MASTER_ENABLE: o_prdata <= {24'h000000, auto_alarm_master_enable_r};
					default: begin
						o_prdata <= 32'h00000000;
						o_pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	assign ais_cond = auto_alarm_master_enable_r[0] & |(auto_alarm_master_enable_r[7:1] & {i_defect.trace_unstable,
		i_defect.trace_mismatch, i_defect.sf, i_defect.sd, i_defect.loss_of_carrier,
		lof_w, i_defect.los});

	// Downstream consumers are told in the same cycle so their defects never lag the AIS.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_path_ais <= 1'b0;
			o_poh_ais_defect <= 1'b0;
			o_cell_lcd_defect <= 1'b0;
		end else begin
			o_path_ais <= ais_cond;
			o_poh_ais_defect <= ais_cond;
			o_cell_lcd_defect <= ais_cond;
		end
	end

	state_onehot_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$onehot(state_r)) else $error("alignment state not one-hot");
	reset_start_a: assert property (@(posedge i_core_clk)
		!i_rst_n |=> state_r == FA_SEF1_LOF1 && status_w[2:1] == 2'b11)
		else $error("reset did not enter SEF=1/LOF=1");
	sef_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF1_LOF1 && frame_done_r && !frame_bad_r && good_cnt_r == 5'h01
		|=> state_r == FA_SEF0_LOF1) else $error("two good frames did not clear SEF");
	sef0_status_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF0_LOF1 |-> !status_w[1] && status_w[2])
		else $error("SEF=0/LOF=1 status wrong");
	sef_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$changed(sef_w) && irq_en_r[1] |-> ##[1:2] (irq_r[1] && !o_irq_n))
		else $error("SEF change gave no interrupt");
	read_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		apb_fire && !i_pwrite && idx_w == IDX_IRQ_STATUS && events_w == 8'h00
		|=> (irq_r & $past(o_prdata[7:0])) == 8'h00) else $error("read did not clear");
	los_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(i_defect.los) |=> irq_r[0] && !status_w[0]) else $error("LOS clear not flagged");
	ais_los_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_defect.los && auto_alarm_master_enable_r[1:0] == 2'b11 |=> o_path_ais)
		else $error("LOS did not insert path AIS");
	ais_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_path_ais == o_poh_ais_defect) else $error("path AIS defect not declared");
	lcd_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_path_ais == o_cell_lcd_defect) else $error("cell delineation loss not declared");
	a1_err_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_line.valid && i_line.frame_start && i_line.byte_data != A1_PATTERN |=> chk_err_r)
		else $error("bad A1 byte not flagged");

	// The exits from SEF=0/LOF=1, the SEF=1/LOF=0 status, the LOF interrupt and the interrupt pin's level are checked on their own as well.
	lof_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$changed(lof_w) && irq_en_r[2] |-> ##[1:2] (irq_r[2] && !o_irq_n))
		else $error("LOF change gave no interrupt");
	irq_level_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(irq_r & irq_en_r) != 8'h00 |=> !o_irq_n)
		else $error("pending interrupt not signalled");
	sef_only_status_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF1_LOF0 |-> status_w[2:1] == 2'b01)
		else $error("SEF=1/LOF=0 status wrong");
	lof_return_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF0_LOF1 && frame_done_r && frame_bad_r && bad_cnt_r == 5'h03
		|=> state_r == FA_SEF1_LOF1) else $error("four bad frames did not declare SEF");
	in_sync_exit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF0_LOF1 && frame_done_r && !frame_bad_r && good_cnt_r + 5'h01 >= sync_need
		|=> state_r == FA_IN_FRAME) else $error("in-sync threshold did not clear LOF");

	in_frame_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_IN_FRAME);
	sef_only_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF1_LOF0);
	ais_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(o_path_ais));
	irq_read_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		apb_fire && !i_pwrite && idx_w == IDX_IRQ_STATUS && o_prdata[1]);
	sef0_lof1_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == FA_SEF0_LOF1);
endmodule
`default_nettype wire

//--- include/rxfa_pkg.sv
// Package with register map, framing constants and carrier types of the receive framer.
`default_nettype none
package rxfa_pkg;
	localparam int APB_AW = 16;
	localparam logic [13:0] IDX_STATUS = 14'h1107;
	localparam logic [13:0] IDX_IRQ_STATUS = 14'h110B;
	localparam logic [13:0] IDX_IRQ_ENABLE = 14'h110F;
	localparam logic [13:0] IDX_IN_SYNC = 14'h112B;
	localparam logic [13:0] IDX_AUTO_ALARM_MASTER_ENABLE = 14'h1163;
	localparam logic [7:0] RST_AUTO_ALARM_MASTER_ENABLE = 8'h03;
	localparam logic [7:0] RST_IRQ_ENABLE = 8'hFF;
	localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
	localparam logic [3:0] RST_IN_SYNC = 4'h4;
	localparam logic [7:0] A1_PATTERN = 8'hF6;
	localparam logic [7:0] A2_PATTERN = 8'h28;
	localparam logic [4:0] A1_BYTES = 5'h09;
	localparam logic [4:0] LAST_FRAMING_BYTE = 5'h11;
	localparam logic [4:0] SEF_CLEAR_FRAMES = 5'h02;
	localparam logic [4:0] SEF_DECLARE_FRAMES = 5'h04;
	localparam logic [4:0] LOF_DECLARE_FRAMES = 5'h18;
	localparam logic [4:0] CNT_MAX = 5'h1F;
	// Positions within the defect status register.
	localparam int ST_LOS = 0;
	localparam int ST_SEF = 1;
	localparam int ST_LOF = 2;
	localparam int ST_SD = 3;
	localparam int ST_SF = 4;
	// Positions within the interrupt status register.
	localparam int IQ_LOS = 0;
	localparam int IQ_SEF = 1;
	localparam int IQ_LOF = 2;
	localparam int IQ_B1 = 3;
	localparam int IQ_B2 = 4;
	localparam int IQ_REI = 5;
	localparam int IQ_SD = 6;
	localparam int IQ_SF = 7;

	typedef enum logic [3:0] {
		FA_IN_FRAME = 4'b0001,
		FA_SEF1_LOF0 = 4'b0010,
		FA_SEF1_LOF1 = 4'b0100,
		FA_SEF0_LOF1 = 4'b1000
	} rxfa_state_t;

	typedef struct packed {
		logic rdi_l;
		logic s1_unstable;
		logic k1k2_unstable;
		logic sf;
		logic sd;
		logic los;
		logic loss_of_carrier;
		logic trace_mismatch;
		logic trace_unstable;
	} rxfa_defect_t;

	typedef struct packed {
		logic rei_l;
		logic b2_err;
		logic b1_err;
	} rxfa_event_t;

	typedef struct packed {
		logic [7:0] byte_data;
		logic valid;
		logic frame_start;
	} rxfa_line_t;
endpackage
`default_nettype wire
